/* rtl/peak_if.sv */
interface peak_if;
  logic [3:0] sample;
  logic sample_valid;
  logic restart;
  logic [3:0] peak;
  modport holder (
    input sample,
    input sample_valid,
    input restart,
    output peak
  );
  modport user (
    output sample,
    output sample_valid,
    output restart,
    input peak
  );
endinterface

/* rtl/regbank_pkg.sv */
package regbank_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL_ADDR = 8'h2c;
  localparam logic [7:0] REG_DISP_ADDR = 8'h2c;
  localparam logic [7:0] REG_PEAK_ADDR = 8'h2d;
  localparam logic [7:0] REG_GAIN_ADDR = 8'h2e;
  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_BIT = 7;
  localparam int CTRL_CODE_HI = 6;
  localparam int CTRL_CODE_LO = 3;
  localparam int CTRL_SEL_HI = 2;
  localparam int CTRL_SEL_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] CODE_RESET = 4'h0;
  localparam logic [3:0] DISP_RESET = 4'h0;
  localparam logic [3:0] PEAK_RESET = 4'h0;
  localparam logic [3:0] GAIN_RESET = 4'h0;
  localparam logic [3:0] RESERVED_NIBBLE = 4'h0;
  // 3.4 v on the 3.3 v scale, used for the fixed core setting
  localparam logic [3:0] CODE_3V4 = 4'hf;
  // lowest defined code on the 3.3 v scale (2.4 v)
  localparam logic [3:0] CODE_3V3_MIN = 4'h5;
  // ----------------------------------------------------------------
  // supply measurement sources
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MEAS_MAIN = 3'h0,
    MEAS_ANALOG = 3'h1,
    MEAS_DIGITAL = 3'h2,
    MEAS_RF_DRIVER = 3'h3,
    MEAS_MODULATION = 3'h4
  } supply_measure_select_t;
  localparam logic [2:0] MEAS_LAST_VALID = 3'h4;
endpackage

/* rtl/regulator_status_regs.sv */
// Function
// - control bit 7 picks adjust result (0) or written code (1)
// - bits 6..3 hold a writable 4-bit voltage code, reset zero
// - codes step 0.1 v; 5 v mode 3.6..5.1, 3.3 v mode 2.4..3.4
// - 5 v mode: digital and analog regulators fixed at 3.4 v
// - 3.3 v mode: digital and analog follow the rf driver regulator
// - bits 2..0 pick measured supply; codes 5..7 reserved
// - display bits 7..4 show last adjust code, low bits reserved
// - display shares control address, told apart by register space
// - am peak in bits 7..4, held until new reception or clear
// - pm peak in bits 3..0, held until new reception or clear
// - strength codes are log threshold indices, zero is quietest
// - gain state bits 7..4 show overall am gain reduction
// - gain state bits 3..0 show overall pm gain reduction
//
// Implementation choice: the plain strobed port.
module regulator_status_regs (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic space_b_sel,
  output logic [7:0] reg_rdata,
  input wire logic supply_5v_mode,
  input wire logic adjust_done,
  input wire logic [3:0] adjust_code,
  input wire logic rx_start,
  input wire logic clear_strength,
  input wire logic strength_valid,
  input wire logic [3:0] am_strength_sample,
  input wire logic [3:0] pm_strength_sample,
  input wire logic [3:0] am_gain_state,
  input wire logic [3:0] pm_gain_state,
  output logic [3:0] rf_regulator_code,
  output logic [3:0] core_regulator_code,
  output logic core_regulator_fixed,
  output logic regulator_code_undefined,
  output logic [2:0] supply_measure_select,
  output logic supply_measure_reserved
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic mode_external_q;
  logic [3:0] external_code_q;
  logic [2:0] measure_sel_q;
  logic [3:0] adjust_result_q;
  logic [3:0] gain_am_q;
  logic [3:0] gain_pm_q;
  logic [7:0] rdata_q;
  logic [3:0] rf_code_q;
  logic [3:0] core_code_q;
  logic core_fixed_q;
  logic undefined_q;
  logic [2:0] meas_out_q;
  logic meas_reserved_q;
  logic [3:0] rf_code_d;
  logic [7:0] rdata_d;
  logic ctrl_wr;
  logic restart;
  logic armed_q;

  peak_if am_pk ();
  peak_if pm_pk ();

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn || !armed_q);

  // ----------------------------------------------------------------
  // check arming
  // ----------------------------------------------------------------
  // the release edge still runs the flops in reset, so checks started
  // there would expect a step that never happened
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      armed_q <= 1'b0;
    else
      armed_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // low codes have no defined voltage on the 3.3 v scale
  function automatic logic code_is_undefined(input logic [3:0] code, input logic mode5v);
    code_is_undefined = !mode5v && (code < regbank_pkg::CODE_3V3_MIN);
  endfunction

  function automatic logic select_is_reserved(input logic [2:0] sel);
    select_is_reserved = sel > regbank_pkg::MEAS_LAST_VALID;
  endfunction

  // ----------------------------------------------------------------
  // control register writes
  // ----------------------------------------------------------------
  // only space a at the control address is writable
  assign ctrl_wr = reg_wr && !space_b_sel && reg_addr == regbank_pkg::REG_CTRL_ADDR;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_external_q <= regbank_pkg::CTRL_RESET[regbank_pkg::CTRL_MODE_BIT];
      external_code_q <= regbank_pkg::CODE_RESET;
      measure_sel_q <= regbank_pkg::CTRL_RESET[regbank_pkg::CTRL_SEL_HI:regbank_pkg::CTRL_SEL_LO];
    end
    else if (ctrl_wr)
    begin
      mode_external_q <= reg_wdata[regbank_pkg::CTRL_MODE_BIT];
      external_code_q <= reg_wdata[regbank_pkg::CTRL_CODE_HI:regbank_pkg::CTRL_CODE_LO];
      measure_sel_q <= reg_wdata[regbank_pkg::CTRL_SEL_HI:regbank_pkg::CTRL_SEL_LO];
    end
  end

  // ----------------------------------------------------------------
  // adjust result capture
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      adjust_result_q <= regbank_pkg::DISP_RESET;
    else if (adjust_done)
      adjust_result_q <= adjust_code;
  end

  // ----------------------------------------------------------------
  // regulator setting outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    rf_code_d = mode_external_q ? external_code_q : adjust_result_q;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rf_code_q <= regbank_pkg::CODE_RESET;
      core_code_q <= regbank_pkg::CODE_RESET;
      core_fixed_q <= 1'b0;
      undefined_q <= 1'b0;
    end
    else
    begin
      rf_code_q <= rf_code_d;
      // core code is on the 3.3 v scale; 3.4 v is its top code
      core_code_q <= supply_5v_mode ? regbank_pkg::CODE_3V4 : rf_code_d;
      core_fixed_q <= supply_5v_mode;
      undefined_q <= code_is_undefined(rf_code_d, supply_5v_mode);
    end
  end

  // ----------------------------------------------------------------
  // supply measurement select
  // ----------------------------------------------------------------
  // reserved codes are passed on but flagged, the measure logic decides
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meas_out_q <= regbank_pkg::MEAS_MAIN;
      meas_reserved_q <= 1'b0;
    end
    else
    begin
      meas_out_q <= measure_sel_q;
      meas_reserved_q <= select_is_reserved(measure_sel_q);
    end
  end

  // ----------------------------------------------------------------
  // signal strength peaks
  // ----------------------------------------------------------------
  // codes are compared as plain indices: the scale is monotonic
  assign restart = rx_start || clear_strength;
  assign am_pk.sample = am_strength_sample;
  assign am_pk.sample_valid = strength_valid;
  assign am_pk.restart = restart;
  assign pm_pk.sample = pm_strength_sample;
  assign pm_pk.sample_valid = strength_valid;
  assign pm_pk.restart = restart;

  strength_peak_hold am_hold (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pk(am_pk.holder)
  );

  strength_peak_hold pm_hold (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pk(pm_pk.holder)
  );

  // ----------------------------------------------------------------
  // gain reduction state
  // ----------------------------------------------------------------
  // sampled once so a read sees one coherent pair
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gain_am_q <= regbank_pkg::GAIN_RESET;
      gain_pm_q <= regbank_pkg::GAIN_RESET;
    end
    else
    begin
      gain_am_q <= am_gain_state;
      gain_pm_q <= pm_gain_state;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // unmapped addresses and the other space read as zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_rd)
    begin
      if (space_b_sel)
      begin
        if (reg_addr == regbank_pkg::REG_DISP_ADDR)
          rdata_d = {adjust_result_q, regbank_pkg::RESERVED_NIBBLE};
      end
      else
      begin
        unique case (reg_addr)
          regbank_pkg::REG_CTRL_ADDR:
            rdata_d = {mode_external_q, external_code_q, measure_sel_q};
          regbank_pkg::REG_PEAK_ADDR:
            rdata_d = {am_pk.peak, pm_pk.peak};
          regbank_pkg::REG_GAIN_ADDR:
            rdata_d = {gain_am_q, gain_pm_q};
          default:
            rdata_d = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  assign reg_rdata = rdata_q;
  assign rf_regulator_code = rf_code_q;
  assign core_regulator_code = core_code_q;
  assign core_regulator_fixed = core_fixed_q;
  assign regulator_code_undefined = undefined_q;
  assign supply_measure_select = meas_out_q;
  assign supply_measure_reserved = meas_reserved_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_ctrl_write;
    reg_wr && !space_b_sel && reg_addr == regbank_pkg::REG_CTRL_ADDR;
  endsequence

  sequence s_ctrl_read;
    reg_rd && !space_b_sel && reg_addr == regbank_pkg::REG_CTRL_ADDR;
  endsequence

  sequence s_quiet_cycle;
    !reg_wr && !adjust_done;
  endsequence

  sequence s_readonly_write;
    reg_wr && !space_b_sel && reg_addr != regbank_pkg::REG_CTRL_ADDR;
  endsequence

  AST_MODE_SELECTS_SOURCE: assert property (
    s_ctrl_write ##1 s_quiet_cycle |=>
      rf_regulator_code == ($past(reg_wdata[7], 2) ? $past(reg_wdata[6:3], 2)
                                                    : $past(adjust_result_q)))
    else $error("regulator code from wrong source");
  AST_CODE_WRITE_READBACK: assert property (
    s_ctrl_write ##1 s_ctrl_read |=> reg_rdata == $past(reg_wdata, 2))
    else $error("control register readback mismatch");
  AST_CORE_FIXED_5V: assert property (
    supply_5v_mode |=> core_regulator_fixed && core_regulator_code == 4'hf)
    else $error("core regulators not fixed in 5 v mode");
  AST_CORE_FOLLOWS_RF: assert property (
    !supply_5v_mode |=> !core_regulator_fixed && core_regulator_code == $past(rf_code_d))
    else $error("core regulators not following rf driver");
  AST_UNDEFINED_FLAG: assert property (
    (!supply_5v_mode && rf_code_d < 4'h5) |=> regulator_code_undefined)
    else $error("undefined low code not flagged");
  AST_MEASURE_SELECT: assert property (
    s_ctrl_write |=> ##1 supply_measure_select == $past(reg_wdata[2:0], 2)
      && supply_measure_reserved == ($past(reg_wdata[2:0], 2) > 3'h4))
    else $error("measure select mismatch");
  AST_DISPLAY_READ: assert property (
    (reg_rd && space_b_sel && reg_addr == 8'h2c) |=>
      reg_rdata == {$past(adjust_result_q), 4'h0})
    else $error("display register read wrong");
  AST_SPACE_B_NO_WRITE: assert property (
    (reg_wr && space_b_sel) |=> $stable(external_code_q) && $stable(mode_external_q))
    else $error("space b write changed control register");
  AST_PEAK_READ: assert property (
    (reg_rd && !space_b_sel && reg_addr == 8'h2d) |=>
      reg_rdata == {$past(am_pk.peak), $past(pm_pk.peak)})
    else $error("peak register read wrong");
  AST_PEAK_CLEAR: assert property (
    clear_strength |=> am_pk.peak == 4'h0 && pm_pk.peak == 4'h0)
    else $error("peaks not cleared");
  AST_GAIN_READ: assert property (
    ##1 (reg_rd && !space_b_sel && reg_addr == 8'h2e) |=>
      reg_rdata == {$past(am_gain_state, 2), $past(pm_gain_state, 2)})
    else $error("gain state read wrong");
  AST_GAIN_PM: assert property (
    ##1 1'b1 |-> gain_pm_q == $past(pm_gain_state))
    else $error("pm gain state not tracked");
  AST_READ_ONE_CYCLE: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  AST_ADJUST_CAPTURE: assert property (
    adjust_done |=> adjust_result_q == $past(adjust_code))
    else $error("adjust result not captured");
  AST_SETTING_HOLDS: assert property (
    s_quiet_cycle |=> ##1 $stable(rf_regulator_code))
    else $error("regulator code changed without a cause");
  AST_UNDEFINED_CLEAR: assert property (
    (supply_5v_mode || rf_code_d >= regbank_pkg::CODE_3V3_MIN) |=> !regulator_code_undefined)
    else $error("defined code flagged undefined");
  AST_RO_NO_WRITE: assert property (
    s_readonly_write |=>
      $stable(mode_external_q) && $stable(external_code_q) && $stable(measure_sel_q))
    else $error("read-only write changed control register");
  AST_PEAK_RX_START: assert property (
    rx_start |=>
      am_pk.peak == regbank_pkg::PEAK_RESET && pm_pk.peak == regbank_pkg::PEAK_RESET)
    else $error("peaks not cleared at reception start");
  AST_SPACE_B_OTHER_READ: assert property (
    (reg_rd && space_b_sel && reg_addr != regbank_pkg::REG_DISP_ADDR) |=>
      reg_rdata == 8'h00)
    else $error("space b read outside display returned data");
endmodule

/* rtl/strength_peak_hold.sv */
module strength_peak_hold (
  input wire logic ref_clk,
  input wire logic resetn,
  peak_if.holder pk
);
  logic [3:0] peak_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // peak tracking
  // ----------------------------------------------------------------
  // restart takes priority so a stale peak never survives into a new frame
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      peak_q <= regbank_pkg::PEAK_RESET;
    else if (pk.restart)
      peak_q <= regbank_pkg::PEAK_RESET;
    else if (pk.sample_valid && pk.sample > peak_q)
      peak_q <= pk.sample;
  end

  assign pk.peak = peak_q;

  AST_PEAK_HOLDS: assert property (
    (!pk.restart && !(pk.sample_valid && pk.sample > pk.peak)) |=> $stable(pk.peak))
    else $error("peak changed without a larger sample");
  AST_PEAK_CAPTURE: assert property (
    (!pk.restart && pk.sample_valid && pk.sample > pk.peak) |=> pk.peak == $past(pk.sample))
    else $error("larger sample not captured");
  AST_PEAK_RESTART: assert property (
    pk.restart |=> pk.peak == regbank_pkg::PEAK_RESET)
    else $error("peak not cleared on restart");
endmodule

/* verification/testbench.sv */
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("Error t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic ref_clk, resetn, reg_wr, reg_rd, space_b_sel, supply_5v_mode;
  logic adjust_done, rx_start, clear_strength, strength_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] adjust_code, am_strength_sample, pm_strength_sample;
  logic [3:0] am_gain_state, pm_gain_state, rf_regulator_code, core_regulator_code;
  logic core_regulator_fixed, regulator_code_undefined, supply_measure_reserved;
  logic [2:0] supply_measure_select;
  logic rd_seen;
  logic [7:0] exp_v;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  regulator_status_regs i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .space_b_sel(space_b_sel), .reg_rdata(reg_rdata),
    .supply_5v_mode(supply_5v_mode), .adjust_done(adjust_done),
    .adjust_code(adjust_code), .rx_start(rx_start), .clear_strength(clear_strength),
    .strength_valid(strength_valid), .am_strength_sample(am_strength_sample),
    .pm_strength_sample(pm_strength_sample), .am_gain_state(am_gain_state),
    .pm_gain_state(pm_gain_state), .rf_regulator_code(rf_regulator_code),
    .core_regulator_code(core_regulator_code),
    .core_regulator_fixed(core_regulator_fixed),
    .regulator_code_undefined(regulator_code_undefined),
    .supply_measure_select(supply_measure_select),
    .supply_measure_reserved(supply_measure_reserved)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // bus driver: one cycle per call, strobes held until the next call
  // ----------------------------------------------------------------
  task automatic op(input logic wr, input logic rd, input logic [7:0] addr,
                    input logic [7:0] data, input logic space_b, input logic [7:0] exp);
    reg_wr <= wr;
    reg_rd <= rd;
    reg_addr <= addr;
    reg_wdata <= data;
    space_b_sel <= space_b;
    if (rd)
      exp_q.push_back(exp);
    @(posedge ref_clk);
  endtask

  task automatic idle();
    op(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, 8'h00);
  endtask

  // outputs settle at the falling edge; resume on the rising one
  task automatic check_regs(input logic [3:0] code, input logic [2:0] sel);
    @(negedge ref_clk);
    `CHK(rf_regulator_code, code)
    `CHK(core_regulator_code, supply_5v_mode ? regbank_pkg::CODE_3V4 : code)
    `CHK(core_regulator_fixed, supply_5v_mode)
    `CHK(regulator_code_undefined, !supply_5v_mode && code < 4'h5)
    `CHK(supply_measure_select, sel)
    `CHK(supply_measure_reserved, sel > 3'h4)
    @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // read monitor: data stands only in the cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge resetn)
    if (!resetn)
      rd_seen <= 1'b0;
    else
      rd_seen <= reg_rd;

  always @(negedge ref_clk)
    if (rd_seen)
    begin
      `CHK(exp_q.size() > 0, 1'b1)
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'h00;
      `CHK(reg_rdata, exp_v)
    end

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d pending %0d", cmp_count, num_errors, exp_q.size());
    if (num_errors == 0 && cmp_count > 0 && exp_q.size() == 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] w;
    logic [3:0] code, c, amax, pmax, a, p;
    logic [2:0] sel;
    resetn = 1'b0;
    {reg_wr, reg_rd, space_b_sel, supply_5v_mode, adjust_done} = '0;
    {rx_start, clear_strength, strength_valid} = '0;
    {reg_addr, reg_wdata} = '0;
    {adjust_code, am_strength_sample, pm_strength_sample} = '0;
    am_gain_state = 4'h9;
    pm_gain_state = 4'h3;
    void'($urandom(32'h7d4f));
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    op(1'b0, 1'b1, 8'h2c, 8'h00, 1'b0, 8'h00);
    op(1'b0, 1'b1, 8'h2c, 8'h00, 1'b1, 8'h00);
    op(1'b0, 1'b1, 8'h2d, 8'h00, 1'b0, 8'h00);
    op(1'b0, 1'b1, 8'h2e, 8'h00, 1'b0, 8'h93);
    idle();
    check_regs(4'h0, 3'h0);
    // every measure source, written code applied, both supply modes
    for (int i = 0; i < 8; i++)
    begin
      supply_5v_mode <= i[0];
      code = 4'($urandom);
      sel = i[2:0];
      w = {1'b1, code, sel};
      op(1'b1, 1'b0, 8'h2c, w, 1'b0, 8'h00);
      op(1'b0, 1'b1, 8'h2c, 8'h00, 1'b0, w);
      idle();
      check_regs(code, sel);
    end
    // read-only places and space b refuse writes; unmapped reads zero
    op(1'b1, 1'b0, 8'h2d, 8'hff, 1'b0, 8'h00);
    op(1'b1, 1'b0, 8'h2e, 8'hff, 1'b0, 8'h00);
    op(1'b1, 1'b0, 8'h2c, 8'h55, 1'b1, 8'h00);
    op(1'b0, 1'b1, 8'h2c, 8'h00, 1'b0, w);
    op(1'b0, 1'b1, 8'h40, 8'h00, 1'b0, 8'h00);
    op(1'b0, 1'b1, 8'h2c, 8'h00, 1'b1, 8'h00);
    op(1'b0, 1'b1, 8'h2d, 8'h00, 1'b0, 8'h00);
    // adjust result applies only with the mode bit clear
    for (int m = 0; m < 2; m++)
    begin
      code = 4'($urandom);
      c = 4'($urandom);
      sel = 3'($urandom_range(4, 0));
      // adjust result lands in the same cycle as the write
      adjust_done <= 1'b1;
      adjust_code <= c;
      op(1'b1, 1'b0, 8'h2c, {m[0], code, sel}, 1'b0, 8'h00);
      adjust_done <= 1'b0;
      op(1'b0, 1'b1, 8'h2c, 8'h00, 1'b1, {c, 4'h0});
      idle();
      check_regs(m ? code : c, sel);
    end
    // running peak per channel, ended by reception start or clear
    for (int k = 0; k < 2; k++)
    begin
      amax = 4'h0;
      pmax = 4'h0;
      for (int i = 0; i < 6; i++)
      begin
        a = (i == 3) ? 4'hf : 4'($urandom);
        p = 4'($urandom);
        strength_valid <= 1'b1;
        am_strength_sample <= a;
        pm_strength_sample <= p;
        idle();
        amax = (a > amax) ? a : amax;
        pmax = (p > pmax) ? p : pmax;
      end
      strength_valid <= 1'b0;
      op(1'b0, 1'b1, 8'h2d, 8'h00, 1'b0, {amax, pmax});
      op(1'b0, 1'b1, 8'h2d, 8'h00, 1'b1, 8'h00);
      if (k == 0)
        rx_start <= 1'b1;
      else
        clear_strength <= 1'b1;
      idle();
      rx_start <= 1'b0;
      clear_strength <= 1'b0;
      op(1'b0, 1'b1, 8'h2d, 8'h00, 1'b0, 8'h00);
    end
    // gain state follows the receiver
    repeat (3)
    begin
      a = 4'($urandom);
      p = 4'($urandom);
      am_gain_state <= a;
      pm_gain_state <= p;
      idle();
      op(1'b0, 1'b1, 8'h2e, 8'h00, 1'b0, {a, p});
    end
    // second reset in mid-run brings the control back to zero
    idle();
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    op(1'b0, 1'b1, 8'h2c, 8'h00, 1'b0, 8'h00);
    op(1'b0, 1'b1, 8'h2c, 8'h00, 1'b1, 8'h00);
    idle();
    check_regs(4'h0, 3'h0);
    conclude();
  end
endmodule
